// ==== rtl/iepr_pkg.sv ====
// Constants shared by the interrupt enable and priority register block.
package iepr_pkg;

	// Special function register byte addresses.
	localparam logic [7:0] IEPR_ADDR_PRIO_BASE = 8'hb8;
	localparam logic [7:0] IEPR_ADDR_MASK_ONE  = 8'he6;
	localparam logic [7:0] IEPR_ADDR_LEVEL_ONE = 8'hf6;

	// Reset values, writable bits and bits that always read as one.
	localparam logic [7:0] IEPR_RST_PRIO_BASE   = 8'h80;
	localparam logic [7:0] IEPR_RST_MASK_ONE    = 8'h00;
	localparam logic [7:0] IEPR_RST_LEVEL_ONE   = 8'h00;
	localparam logic [7:0] IEPR_WR_PRIO_BASE    = 8'h7f;
	localparam logic [7:0] IEPR_WR_ALL          = 8'hff;
	localparam logic [7:0] IEPR_ONES_PRIO_BASE  = 8'h80;
	localparam logic [7:0] IEPR_ONES_NONE       = 8'h00;

	// Bit addresses of a bit-addressable register share its upper five bits.
	localparam int IEPR_BIT_SEL_W = 3;

	// Field positions in the base priority register.
	localparam int IEPR_POS_EXT_INT_ZERO_LEVEL = 0;
	localparam int IEPR_POS_TIMER_ZERO_LEVEL   = 1;
	localparam int IEPR_POS_EXT_INT_ONE_LEVEL  = 2;
	localparam int IEPR_POS_TIMER_ONE_LEVEL    = 3;
	localparam int IEPR_POS_UART_LEVEL         = 4;
	localparam int IEPR_POS_TIMER_TWO_LEVEL    = 5;
	localparam int IEPR_POS_SERIAL_PERIPH_LVL  = 6;
	localparam int IEPR_NUM_BASE_SRC           = 7;

	// Field positions shared by the extended mask and extended level registers.
	localparam int IEPR_POS_SMBUS         = 0;
	localparam int IEPR_POS_RESERVED_ONE  = 1;
	localparam int IEPR_POS_WINDOW_CMP    = 2;
	localparam int IEPR_POS_CONV_DONE     = 3;
	localparam int IEPR_POS_COUNTER_ARRAY = 4;
	localparam int IEPR_POS_COMP_ZERO     = 5;
	localparam int IEPR_POS_COMP_ONE      = 6;
	localparam int IEPR_POS_TIMER_THREE   = 7;

	// Fixed priority order positions; a lower index is served first.
	localparam int IEPR_NUM_SRC       = 15;
	localparam int IEPR_IDX_W         = 4;
	localparam int IEPR_IDX_SMBUS     = 7;
	localparam int IEPR_IDX_RESERVED  = 8;
	localparam int IEPR_IDX_WINDOW    = 9;
	localparam int IEPR_IDX_CONV_DONE = 10;
	localparam int IEPR_IDX_CNT_ARRAY = 11;
	localparam int IEPR_IDX_COMP_ZERO = 12;
	localparam int IEPR_IDX_COMP_ONE  = 13;
	localparam int IEPR_IDX_TIMER_3   = 14;

	// Service nesting state, one-hot.
	typedef enum logic [3:0] {
		IEPR_SVC_NONE     = 4'b0001,
		IEPR_SVC_LOW      = 4'b0010,
		IEPR_SVC_HIGH     = 4'b0100,
		IEPR_SVC_HIGH_LOW = 4'b1000
	} iepr_svc_t;

endpackage : iepr_pkg

// ==== rtl/iepr_sfr_byte.sv ====
// One special function register byte with whole-byte and single-bit writes.
`timescale 1ns/100ps
module iepr_sfr_byte #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WR_MASK   = 8'hff,
	parameter logic [7:0] ONES_MASK = 8'h00
) (
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire logic       wr_byte_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_bit_i,
	input  wire logic [2:0] bit_sel_i,
	input  wire logic       bit_val_i,
	output logic      [7:0] q_o
);

	logic [7:0] store_q;
	logic [7:0] store_d;
	logic [7:0] bit_onehot;

	// A single-bit write only touches the selected bit, like a read-modify-write.
	assign bit_onehot = 8'h01 << bit_sel_i;
	assign store_d    = wr_byte_i ? (wdata_i & WR_MASK) :
	                    wr_bit_i  ? ((store_q & ~(bit_onehot & WR_MASK)) |
	                                 ({8{bit_val_i}} & bit_onehot & WR_MASK)) :
	                    store_q;

	// Bits outside the write mask never change, so constant bits stay put.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			store_q <= RESET_VAL & WR_MASK;
		end else begin
			store_q <= store_d;
		end
	end

	// Read value forces the fixed-one bits.
	assign q_o = (store_q & WR_MASK) | ONES_MASK;

endmodule : iepr_sfr_byte

// ==== rtl/iepr_pick.sv ====
// Finds the lowest set position of a request vector.
`timescale 1ns/100ps
module iepr_pick #(
	parameter int N   = 15,
	parameter int IDX = 4
) (
	input  wire logic [N-1:0]   req_i,
	output logic                found_o,
	output logic      [IDX-1:0] idx_o
);

	// Scan from the top so the lowest index is the last to win.
	always_comb begin
		found_o = 1'b0;
		idx_o   = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (req_i[k]) begin
				found_o = 1'b1;
				idx_o   = IDX'(k);
			end
		end
	end

endmodule : iepr_pick

// ==== rtl/iepr_top.sv ====
// Interrupt enable masking, level registers and two-level request selection.
`timescale 1ns/100ps
module iepr_top
	import iepr_pkg::*;
(
	input  wire logic                                clk_sys_i,
	input  wire logic                                resetn_i,
	input  wire logic                          [7:0] sfr_addr_i,
	input  wire logic                                sfr_wr_i,
	input  wire logic                                sfr_rd_i,
	input  wire logic                          [7:0] sfr_wdata_i,
	input  wire logic                          [7:0] sfr_bit_addr_i,
	input  wire logic                                sfr_bit_wr_i,
	input  wire logic                                sfr_bit_rd_i,
	input  wire logic                                sfr_bit_wdata_i,
	input  wire logic                                global_interrupt_gate_i,
	input  wire logic [iepr_pkg::IEPR_NUM_BASE_SRC-1:0] base_enable_i,
	input  wire logic [iepr_pkg::IEPR_NUM_BASE_SRC-1:0] base_flag_i,
	input  wire logic                                timer_three_low_overflow_i,
	input  wire logic                                timer_three_high_overflow_i,
	input  wire logic                                comparator_one_rise_flag_i,
	input  wire logic                                comparator_one_fall_flag_i,
	input  wire logic                                comparator_zero_rise_flag_i,
	input  wire logic                                comparator_zero_fall_flag_i,
	input  wire logic                                counter_array_req_i,
	input  wire logic                                conversion_done_flag_i,
	input  wire logic                                window_compare_flag_i,
	input  wire logic                                smbus_port_req_i,
	input  wire logic                                irq_ack_i,
	input  wire logic                                irq_return_i,
	output logic                               [7:0] sfr_rdata_o,
	output logic                                     sfr_hit_o,
	output logic                                     sfr_bit_rdata_o,
	output logic                                     irq_req_o,
	output logic        [iepr_pkg::IEPR_IDX_W-1:0]   irq_index_o,
	output logic                                     irq_level_o,
	output logic                               [1:0] in_service_o
);

	import iepr_pkg::*;

	// Byte address decode, shared by reads and writes.
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] base);
		addr_is = (addr == base);
	endfunction : addr_is

	// Bit address decode: the upper five bits name the bit-addressable byte.
	function automatic logic bit_addr_is(input logic [7:0] addr, input logic [7:0] base);
		bit_addr_is = (addr[7:IEPR_BIT_SEL_W] == base[7:IEPR_BIT_SEL_W]);
	endfunction : bit_addr_is

	logic                    sel_prio_base;
	logic                    sel_mask_one;
	logic                    sel_level_one;
	logic                    bit_sel_prio_base;
	logic                    any_sel;
	logic              [7:0] prio_base_val;
	logic              [7:0] mask_one_val;
	logic              [7:0] level_one_val;
	logic              [7:0] rdata_mux;
	logic                    bit_rdata_mux;
	logic [IEPR_NUM_SRC-1:0] src_req;
	logic [IEPR_NUM_SRC-1:0] src_level;
	logic [IEPR_NUM_SRC-1:0] gated_req;
	logic [IEPR_NUM_SRC-1:0] high_req;
	logic [IEPR_NUM_SRC-1:0] low_req;
	logic                    high_found;
	logic                    low_found;
	logic   [IEPR_IDX_W-1:0] high_idx;
	logic   [IEPR_IDX_W-1:0] low_idx;
	logic                    high_allowed;
	logic                    low_allowed;
	logic                    req_d;
	logic   [IEPR_IDX_W-1:0] idx_d;
	logic                    level_d;
	logic                    req_q;
	logic   [IEPR_IDX_W-1:0] idx_q;
	logic                    level_q;
	logic              [7:0] rdata_q;
	logic                    hit_q;
	logic                    bit_rdata_q;
	iepr_svc_t               svc_q;
	iepr_svc_t               svc_d;

	// Register selection for byte and bit accesses.
	assign sel_prio_base     = addr_is(sfr_addr_i, IEPR_ADDR_PRIO_BASE);
	assign sel_mask_one      = addr_is(sfr_addr_i, IEPR_ADDR_MASK_ONE);
	assign sel_level_one     = addr_is(sfr_addr_i, IEPR_ADDR_LEVEL_ONE);
	assign bit_sel_prio_base = bit_addr_is(sfr_bit_addr_i, IEPR_ADDR_PRIO_BASE);
	assign any_sel           = sel_prio_base | sel_mask_one | sel_level_one;

	// Base priority byte: top bit has no storage and reads back as one.
	iepr_sfr_byte #(
		.RESET_VAL (IEPR_RST_PRIO_BASE),
		.WR_MASK   (IEPR_WR_PRIO_BASE),
		.ONES_MASK (IEPR_ONES_PRIO_BASE)
	) u_prio_base (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_byte_i (sfr_wr_i & sel_prio_base),
		.wdata_i   (sfr_wdata_i),
		.wr_bit_i  (sfr_bit_wr_i & bit_sel_prio_base),
		.bit_sel_i (sfr_bit_addr_i[IEPR_BIT_SEL_W-1:0]),
		.bit_val_i (sfr_bit_wdata_i),
		.q_o       (prio_base_val)
	);

	// Extended mask byte; the reserved bit is stored but steers nothing.
	iepr_sfr_byte #(
		.RESET_VAL (IEPR_RST_MASK_ONE),
		.WR_MASK   (IEPR_WR_ALL),
		.ONES_MASK (IEPR_ONES_NONE)
	) u_mask_one (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_byte_i (sfr_wr_i & sel_mask_one),
		.wdata_i   (sfr_wdata_i),
		.wr_bit_i  (1'b0),
		.bit_sel_i (3'h0),
		.bit_val_i (1'b0),
		.q_o       (mask_one_val)
	);

	// Extended level byte, byte access only.
	iepr_sfr_byte #(
		.RESET_VAL (IEPR_RST_LEVEL_ONE),
		.WR_MASK   (IEPR_WR_ALL),
		.ONES_MASK (IEPR_ONES_NONE)
	) u_level_one (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_byte_i (sfr_wr_i & sel_level_one),
		.wdata_i   (sfr_wdata_i),
		.wr_bit_i  (1'b0),
		.bit_sel_i (3'h0),
		.bit_val_i (1'b0),
		.q_o       (level_one_val)
	);

	// Read multiplexers; an address this block does not own reads as zero.
	assign rdata_mux     = sel_prio_base ? prio_base_val :
	                       sel_mask_one  ? mask_one_val  :
	                       sel_level_one ? level_one_val : 8'h00;
	assign bit_rdata_mux = bit_sel_prio_base &
	                       prio_base_val[sfr_bit_addr_i[IEPR_BIT_SEL_W-1:0]];

	// Read data are registered so the core sees them one edge after the strobe.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q     <= 8'h00;
			hit_q       <= 1'b0;
			bit_rdata_q <= 1'b0;
		end else begin
			rdata_q     <= sfr_rd_i ? rdata_mux : rdata_q;
			hit_q       <= (sfr_rd_i | sfr_wr_i) & any_sel;
			bit_rdata_q <= sfr_bit_rd_i ? bit_rdata_mux : bit_rdata_q;
		end
	end

	// Base sources keep their own order: level bit k belongs to order k.
	generate
		for (genvar k = 0; k < IEPR_NUM_BASE_SRC; k++) begin : g_base
			assign src_req[k]   = base_enable_i[k] & base_flag_i[k];
			assign src_level[k] = prio_base_val[k];
		end
	endgenerate

	// Extended sources, each gated by its own mask bit.
	assign src_req[IEPR_IDX_SMBUS]     = mask_one_val[IEPR_POS_SMBUS] &
	                                     smbus_port_req_i;
	assign src_req[IEPR_IDX_RESERVED]  = 1'b0;
	assign src_req[IEPR_IDX_WINDOW]    = mask_one_val[IEPR_POS_WINDOW_CMP] &
	                                     window_compare_flag_i;
	assign src_req[IEPR_IDX_CONV_DONE] = mask_one_val[IEPR_POS_CONV_DONE] &
	                                     conversion_done_flag_i;
	assign src_req[IEPR_IDX_CNT_ARRAY] = mask_one_val[IEPR_POS_COUNTER_ARRAY] &
	                                     counter_array_req_i;
	assign src_req[IEPR_IDX_COMP_ZERO] = mask_one_val[IEPR_POS_COMP_ZERO] &
	                                     (comparator_zero_rise_flag_i |
	                                      comparator_zero_fall_flag_i);
	assign src_req[IEPR_IDX_COMP_ONE]  = mask_one_val[IEPR_POS_COMP_ONE] &
	                                     (comparator_one_rise_flag_i |
	                                      comparator_one_fall_flag_i);
	assign src_req[IEPR_IDX_TIMER_3]   = mask_one_val[IEPR_POS_TIMER_THREE] &
	                                     (timer_three_low_overflow_i |
	                                      timer_three_high_overflow_i);

	// Extended levels; the reserved order slot has no level of its own.
	assign src_level[IEPR_IDX_SMBUS]     = level_one_val[IEPR_POS_SMBUS];
	assign src_level[IEPR_IDX_RESERVED]  = 1'b0;
	assign src_level[IEPR_IDX_WINDOW]    = level_one_val[IEPR_POS_WINDOW_CMP];
	assign src_level[IEPR_IDX_CONV_DONE] = level_one_val[IEPR_POS_CONV_DONE];
	assign src_level[IEPR_IDX_CNT_ARRAY] = level_one_val[IEPR_POS_COUNTER_ARRAY];
	assign src_level[IEPR_IDX_COMP_ZERO] = level_one_val[IEPR_POS_COMP_ZERO];
	assign src_level[IEPR_IDX_COMP_ONE]  = level_one_val[IEPR_POS_COMP_ONE];
	assign src_level[IEPR_IDX_TIMER_3]   = level_one_val[IEPR_POS_TIMER_THREE];

	// Global gate sits ahead of every mask, then requests split by level.
	assign gated_req = src_req & {IEPR_NUM_SRC{global_interrupt_gate_i}};
	assign high_req  = gated_req & src_level;
	assign low_req   = gated_req & ~src_level;

	// One finder per level keeps the fixed order independent of the other level.
	iepr_pick #(
		.N   (IEPR_NUM_SRC),
		.IDX (IEPR_IDX_W)
	) u_pick_high (
		.req_i   (high_req),
		.found_o (high_found),
		.idx_o   (high_idx)
	);

	iepr_pick #(
		.N   (IEPR_NUM_SRC),
		.IDX (IEPR_IDX_W)
	) u_pick_low (
		.req_i   (low_req),
		.found_o (low_found),
		.idx_o   (low_idx)
	);

	// A high request may enter over low service only; low needs an idle core.
	assign high_allowed = (svc_q == IEPR_SVC_NONE) | (svc_q == IEPR_SVC_LOW);
	assign low_allowed  = (svc_q == IEPR_SVC_NONE);

	// The cycle after an acknowledge presents nothing, since the pending flag
	// of the taken source is still set and would be offered twice.
	assign req_d   = ~irq_ack_i & ((high_found & high_allowed) |
	                               (low_found & low_allowed));
	assign idx_d   = (high_found & high_allowed) ? high_idx : low_idx;
	assign level_d = high_found & high_allowed;

	// Service nesting: an acknowledge pushes the offered level, a return
	// pops the innermost one; both in one cycle swap low for high.
	always_comb begin
		svc_d = svc_q;
		case (svc_q)
			IEPR_SVC_NONE: begin
				if (irq_ack_i & req_q) begin
					svc_d = level_q ? IEPR_SVC_HIGH : IEPR_SVC_LOW;
				end
			end
			IEPR_SVC_LOW: begin
				if (irq_ack_i & req_q & level_q) begin
					svc_d = irq_return_i ? IEPR_SVC_HIGH : IEPR_SVC_HIGH_LOW;
				end else if (irq_return_i) begin
					svc_d = IEPR_SVC_NONE;
				end
			end
			IEPR_SVC_HIGH: begin
				if (irq_return_i) begin
					svc_d = IEPR_SVC_NONE;
				end
			end
			IEPR_SVC_HIGH_LOW: begin
				if (irq_return_i) begin
					svc_d = IEPR_SVC_LOW;
				end
			end
			default: begin
				svc_d = IEPR_SVC_NONE;
			end
		endcase
	end

	// Request and service state registers.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_q   <= 1'b0;
			idx_q   <= '0;
			level_q <= 1'b0;
			svc_q   <= IEPR_SVC_NONE;
		end else begin
			req_q   <= req_d;
			idx_q   <= idx_d;
			level_q <= level_d;
			svc_q   <= svc_d;
		end
	end

	// Outputs straight from flip-flops, except in_service_o, decoded from the service state.
	assign sfr_rdata_o     = rdata_q;
	assign sfr_hit_o       = hit_q;
	assign sfr_bit_rdata_o = bit_rdata_q;
	assign irq_req_o       = req_q;
	assign irq_index_o     = idx_q;
	assign irq_level_o     = level_q;
	assign in_service_o    = {(svc_q == IEPR_SVC_HIGH) | (svc_q == IEPR_SVC_HIGH_LOW),
	                          (svc_q == IEPR_SVC_LOW)  | (svc_q == IEPR_SVC_HIGH_LOW)};

endmodule : iepr_top

// ==== sim/iepr_cpu_model.sv ====
// Behavioural model of the CPU core that takes offered requests and returns from them.
`timescale 1ns/100ps
module iepr_cpu_model (
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire logic       irq_req_i,
	input  wire logic [3:0] irq_index_i,
	input  wire logic       ack_en_i,
	input  wire logic [3:0] wait_i,
	input  wire logic       ret_i,
	output logic            irq_ack_o,
	output logic            irq_return_o,
	output logic      [3:0] taken_idx_o
);
	logic [3:0] wait_q;

	// Acks only a standing request after the chosen wait; never twice in a row, since it skips any
	// cycle in which its own ack stands. The taken index is the one offered
	// while the ack stands, because that is the offer the block pairs the ack with.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_q       <= 4'h0;
			irq_ack_o    <= 1'b0;
			irq_return_o <= 1'b0;
			taken_idx_o  <= 4'h0;
		end else begin
			irq_ack_o    <= 1'b0;
			irq_return_o <= ret_i;
			wait_q       <= 4'h0;
			if (irq_ack_o && irq_req_i) begin
				taken_idx_o <= irq_index_i;
			end
			if (irq_req_i && ack_en_i && !irq_ack_o) begin
				if (wait_q >= wait_i) begin
					irq_ack_o <= 1'b1;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule : iepr_cpu_model

// ==== sim/iepr_checker.sv ====
// Port-level checker of register reads and request nesting.
`timescale 1ns/100ps
module iepr_checker (
	input wire logic       clk_sys_i,
	input wire logic       resetn_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_bit_addr_i,
	input wire logic       sfr_bit_rd_i,
	input wire logic       global_interrupt_gate_i,
	input wire logic       irq_ack_i,
	input wire logic       irq_return_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       sfr_hit_o,
	input wire logic       sfr_bit_rdata_o,
	input wire logic       irq_req_o,
	input wire logic       irq_level_o,
	input wire logic [1:0] in_service_o
);
	// Decode of the three mapped byte addresses.
	logic map_w;
	assign map_w = sfr_addr_i inside {8'hb8, 8'he6, 8'hf6};

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_base_top_one: assert property (sfr_rd_i && sfr_addr_i == 8'hb8 |=> sfr_rdata_o[7])
		else $error("base priority top bit read as zero");
	a_bit_top_one: assert property (sfr_bit_rd_i && sfr_bit_addr_i == 8'hbf |=> sfr_bit_rdata_o)
		else $error("bit read of base priority top bit gave zero");
	a_unmapped_zero: assert property (sfr_rd_i && !map_w |=> sfr_rdata_o == 8'h00 && !sfr_hit_o)
		else $error("unmapped read gave data or hit");
	a_hit_mapped: assert property ((sfr_rd_i || sfr_wr_i) && map_w |=> sfr_hit_o)
		else $error("mapped access without hit");
	a_hit_idle: assert property (!sfr_rd_i && !sfr_wr_i |=> !sfr_hit_o)
		else $error("hit without access");
	a_gate_blocks: assert property (!global_interrupt_gate_i |=> !irq_req_o)
		else $error("request offered with global gate clear");
	a_ack_withdraws: assert property (irq_ack_i && irq_req_o |=> !irq_req_o)
		else $error("request still offered after ack");
	a_high_blocks: assert property (in_service_o[1] && !irq_return_i |=> !irq_req_o)
		else $error("request offered during high service");
	a_low_blocks: assert property (in_service_o[0] && !irq_return_i |=> !irq_req_o || irq_level_o)
		else $error("low request offered during low service");
	a_low_push: assert property (irq_ack_i && irq_req_o && !irq_level_o && in_service_o == 2'b00
		&& !irq_return_i |=> in_service_o == 2'b01)
		else $error("low ack did not enter low service");
	a_high_push: assert property (irq_ack_i && irq_req_o && irq_level_o && !irq_return_i
		|=> in_service_o == {1'b1, $past(in_service_o[0])})
		else $error("high ack did not enter high service");

	c_preempt: cover property (irq_ack_i && irq_req_o && irq_level_o && in_service_o[0]);
	c_nested_return: cover property (in_service_o == 2'b11 && irq_return_i);
	c_bit_top: cover property (sfr_bit_rd_i && sfr_bit_addr_i == 8'hbf);
endmodule : iepr_checker

bind iepr_top iepr_checker u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
	.sfr_bit_addr_i(sfr_bit_addr_i), .sfr_bit_rd_i(sfr_bit_rd_i),
	.global_interrupt_gate_i(global_interrupt_gate_i), .irq_ack_i(irq_ack_i),
	.irq_return_i(irq_return_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
	.sfr_bit_rdata_o(sfr_bit_rdata_o), .irq_req_o(irq_req_o), .irq_level_o(irq_level_o),
	.in_service_o(in_service_o));

// ==== sim/iepr_tb.sv ====
// Self-checking bench for the interrupt enable and priority registers.
`timescale 1ns/100ps
module testbench;
	import iepr_pkg::*;
	logic       clk_sys_i, resetn_i, wr, rd, bwr, brd, bval, gate, ack_en, ret;
	logic       hit, brdata, req, lvl, ack, rtn;
	logic [7:0] addr, wdata, baddr, rdata;
	logic [6:0] ben, bflag;
	logic [9:0] xf;
	logic [3:0] wt, idx, tidx;
	logic [1:0] insv;
	int         fail_count, tests_run;
	// Extended mask bit of each flag in xf; its order index is seven above it.
	localparam int MB [10] = '{7, 7, 6, 6, 5, 5, 4, 3, 2, 0};

	iepr_top uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_bit_addr_i(baddr),
		.sfr_bit_wr_i(bwr), .sfr_bit_rd_i(brd), .sfr_bit_wdata_i(bval),
		.global_interrupt_gate_i(gate), .base_enable_i(ben), .base_flag_i(bflag),
		.timer_three_low_overflow_i(xf[0]), .timer_three_high_overflow_i(xf[1]),
		.comparator_one_rise_flag_i(xf[2]), .comparator_one_fall_flag_i(xf[3]),
		.comparator_zero_rise_flag_i(xf[4]), .comparator_zero_fall_flag_i(xf[5]),
		.counter_array_req_i(xf[6]), .conversion_done_flag_i(xf[7]),
		.window_compare_flag_i(xf[8]), .smbus_port_req_i(xf[9]), .irq_ack_i(ack),
		.irq_return_i(rtn), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .sfr_bit_rdata_o(brdata),
		.irq_req_o(req), .irq_index_o(idx), .irq_level_o(lvl), .in_service_o(insv));

	iepr_cpu_model cpu (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .irq_req_i(req),
		.irq_index_i(idx), .ack_en_i(ack_en), .wait_i(wt), .ret_i(ret), .irq_ack_o(ack),
		.irq_return_o(rtn), .taken_idx_o(tidx));

	// Clock at 250 MHz.
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// Compares one byte-sized result; case inequality so unknowns fail.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Bus tasks drive at a rising edge and hold the strobe for exactly one cycle.
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask : wr8

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		@(negedge clk_sys_i);
		chk(rdata, e);
		chk({7'h0, hit}, {7'h0, (a inside {8'hb8, 8'he6, 8'hf6})});
	endtask : rchk

	task automatic bw(input logic [7:0] a, input logic v);
		@(posedge clk_sys_i);
		baddr <= a;
		bval  <= v;
		bwr   <= 1'b1;
		@(posedge clk_sys_i);
		bwr <= 1'b0;
	endtask : bw

	task automatic bchk(input logic [7:0] a, input logic e);
		@(posedge clk_sys_i);
		baddr <= a;
		brd   <= 1'b1;
		@(posedge clk_sys_i);
		brd <= 1'b0;
		@(negedge clk_sys_i);
		chk({7'h0, brdata}, {7'h0, e});
	endtask : bchk

	// Index and level only matter while a request is offered.
	task automatic ck_irq(input logic r, input logic l, input logic [3:0] i);
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(req ? {req, lvl, 2'b00, idx} : 8'h00, {r, l, 2'b00, i});
	endtask : ck_irq

	task automatic wait_svc(input logic [1:0] e);
		for (int n = 0; n < 30 && insv !== e; n++) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk({6'h0, insv}, {6'h0, e});
	endtask : wait_svc

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	// Watchdog: the sequence needs well under 5000 cycles.
	initial begin
		#20000;
		fail_count++;
		stop_test();
	end

	initial begin
		{wr, rd, bwr, brd, bval, gate, ack_en, ret} = '0;
		{addr, wdata, baddr, ben, bflag, xf, wt} = '0;
		fail_count = 0;
		tests_run  = 0;
		resetn_i   = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		rchk(8'hb8, 8'h80);
		rchk(8'he6, 8'h00);
		rchk(8'hf6, 8'h00);
		rchk(8'ha8, 8'h00);
		wr8(8'hb8, 8'h7f);
		rchk(8'hb8, 8'hff);
		wr8(8'hb8, 8'h00);
		rchk(8'hb8, 8'h80);
		bw(8'hba, 1'b1);
		bw(8'hbf, 1'b0);
		bchk(8'hba, 1'b1);
		bchk(8'hbf, 1'b1);
		bchk(8'h90, 1'b0);
		rchk(8'hb8, 8'h84);
		wr8(8'he6, 8'hfd);
		rchk(8'he6, 8'hfd);
		wr8(8'hf6, 8'hff);
		rchk(8'hf6, 8'hff);
		wr8(8'hf6, 8'h00);
		$display("test registers ends");
		// Each flag passes with its own mask bit alone and is blocked by it alone.
		@(posedge clk_sys_i);
		gate <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys_i);
			xf <= 10'h001 << i;
			wr8(8'he6, 8'h01 << MB[i]);
			ck_irq(1'b1, 1'b0, 4'(7 + MB[i]));
			wr8(8'he6, ~(8'h01 << MB[i]) & 8'hfd);
			ck_irq(1'b0, 1'b0, 4'h0);
		end
		wr8(8'he6, 8'hfd);
		gate <= 1'b0;
		ck_irq(1'b0, 1'b0, 4'h0);
		$display("test masks ends");
		// All base sources pending; a single high level bit picks the winner.
		@(posedge clk_sys_i);
		gate  <= 1'b1;
		xf    <= '0;
		ben   <= 7'h7f;
		bflag <= 7'h7f;
		wr8(8'hb8, 8'h00);
		ck_irq(1'b1, 1'b0, 4'h0);
		for (int k = 0; k < 7; k++) begin
			wr8(8'hb8, 8'h01 << k);
			ck_irq(1'b1, 1'b1, 4'(k));
		end
		// Dropping the base enables of the high source and of order 0 leaves order 1.
		@(posedge clk_sys_i);
		ben <= 7'h3e;
		ck_irq(1'b1, 1'b0, 4'h1);
		@(posedge clk_sys_i);
		bflag <= '0;
		xf    <= 10'h3ff;
		wr8(8'hf6, 8'h00);
		ck_irq(1'b1, 1'b0, 4'h7);
		for (int j = 0; j < 8; j++) begin
			if (j != 1) begin
				wr8(8'hf6, 8'h01 << j);
				ck_irq(1'b1, 1'b1, 4'(7 + j));
			end
		end
		$display("test levels ends");
		// Low service taken slowly, then preempted promptly by a high request.
		@(posedge clk_sys_i);
		xf     <= 10'h001;
		wt     <= 4'd2;
		wr8(8'hf6, 8'h01);
		// The core may take requests only once the new levels are in place.
		ack_en <= 1'b1;
		wait_svc(2'b01);
		chk({4'h0, tidx}, 8'h0e);
		ck_irq(1'b0, 1'b0, 4'h0);
		@(posedge clk_sys_i);
		wt <= 4'd0;
		xf <= 10'h201;
		wait_svc(2'b11);
		chk({4'h0, tidx}, 8'h07);
		ck_irq(1'b0, 1'b0, 4'h0);
		@(posedge clk_sys_i);
		ack_en <= 1'b0;
		ret    <= 1'b1;
		@(posedge clk_sys_i);
		ret <= 1'b0;
		wait_svc(2'b01);
		ck_irq(1'b1, 1'b1, 4'h7);
		@(posedge clk_sys_i);
		xf  <= '0;
		ret <= 1'b1;
		@(posedge clk_sys_i);
		ret <= 1'b0;
		wait_svc(2'b00);
		$display("test nesting ends");
		stop_test();
	end
endmodule : testbench
